// ### common/rsfo_pkg.sv
// Package for the rotate-and-set file operation execution block
package rsfo_pkg;
    // Opcode high-byte patterns (bit 8 is the d/s select)
    localparam logic [6:0] RSFO_OP_ROTATE  = 7'h10;  // 0010 000x
    localparam logic [6:0] RSFO_OP_SETONES = 7'h15;  // 0010 101x
    localparam int         RSFO_OP_LSB     = 9;
    localparam int         RSFO_SEL_BIT    = 8;
    localparam logic [7:0] RSFO_ALL_ONES   = 8'hff;
    localparam logic [7:0] RSFO_WORK_RST   = 8'h00;
    localparam logic [7:0] RSFO_DATA_RST   = 8'h00;
    localparam int         RSFO_ADDR_MSB   = 7;
    localparam logic [15:0] RSFO_INSTR_RST = 16'h0000;
    // Four phases of one instruction cycle, Gray coded
    typedef enum logic [1:0] {
        RSFO_Q1 = 2'h0,
        RSFO_Q2 = 2'h1,
        RSFO_Q3 = 2'h3,
        RSFO_Q4 = 2'h2
    } rsfo_phase_t;
endpackage : rsfo_pkg

// ### design/rsfo_exec.sv
// Execution datapath for rotate-right-no-carry and set-file-all-ones
// Operation
// - Rotate shifts the file register right by one, bit 0 wrapping to bit 7, no carry.
// - Rotate with destination select 0 writes the result to the working register only.
// - Rotate with destination select 1 writes the result back to the source file register.
// - Set with store select 0 loads all ones into the file location and working register.
// - Set with store select 1 loads all ones into the file location only.
// - Each operation runs decode, read, execute, write in four phases; a file write strobes in the next cycle's Q1, beside the next decode.
`timescale 1ns/1ps
module rsfo_exec
    import rsfo_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic [15:0] instr_word,
    output logic             instr_take,
    output logic [7:0]       file_addr,
    output logic             file_rd,
    input  wire logic [7:0]  file_rdata,
    output logic             file_we,
    output logic [7:0]       file_wdata,
    output logic [7:0]       working_register,
    output logic             instr_known
);
    rsfo_phase_t phase_reg;
    logic [15:0] instr_reg;
    logic [7:0]  operand_reg;
    logic [7:0]  result_reg;
    logic [7:0]  work_reg;
    logic [7:0]  wdata_reg;
    logic        we_reg;
    logic        is_rot;
    logic        is_set;
    logic        sel;
    logic        dest_file;
    logic        dest_work;
    logic        read_done_reg;

    // Shared opcode match
    function automatic logic op_is(input logic [15:0] w, input logic [6:0] op);
        op_is = (w[15:RSFO_OP_LSB] == op);
    endfunction : op_is

    // Rotate right by one with bit 0 wrapping to bit 7; no carry in or out
    function automatic logic [7:0] rot_right(input logic [7:0] v);
        rot_right = {v[0], v[7:1]};
    endfunction : rot_right

    assign is_rot = op_is(instr_reg, RSFO_OP_ROTATE);
    assign is_set = op_is(instr_reg, RSFO_OP_SETONES);
    assign sel    = instr_reg[RSFO_SEL_BIT];
    assign instr_take       = (phase_reg == RSFO_Q1);
    assign file_addr        = instr_reg[RSFO_ADDR_MSB:0];
    assign file_rd          = (phase_reg == RSFO_Q2) && (is_rot || is_set);
    assign file_we          = we_reg;
    assign file_wdata       = wdata_reg;
    assign working_register = work_reg;
    assign instr_known      = is_rot || is_set;

    // Destinations; an unknown word selects neither, so it writes nothing
    assign dest_file = is_set || (is_rot && sel);
    assign dest_work = (is_rot || is_set) && !sel;

    // Phase sequencer: one instruction per four clocks
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            phase_reg <= RSFO_Q1;
        else
            unique case (phase_reg)
                RSFO_Q1: phase_reg <= RSFO_Q2;
                RSFO_Q2: phase_reg <= RSFO_Q3;
                RSFO_Q3: phase_reg <= RSFO_Q4;
                RSFO_Q4: phase_reg <= RSFO_Q1;
            endcase
    end

    // Decode: latch the instruction word in Q1
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            instr_reg <= RSFO_INSTR_RST;
        else if (phase_reg == RSFO_Q1)
            instr_reg <= instr_word;
    end

    // Read in Q2; the write of the same word comes later, so this copy is clean
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            operand_reg <= RSFO_DATA_RST;
        else if (phase_reg == RSFO_Q2)
            operand_reg <= file_rdata;
    end

    // Execute in Q3
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            result_reg <= RSFO_DATA_RST;
        else if (phase_reg == RSFO_Q3)
            result_reg <= is_set ? RSFO_ALL_ONES : rot_right(operand_reg);
    end

    // File strobe from Q4, up for one cycle; no status flags exist here
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            we_reg <= 1'h0;
        else
            we_reg <= (phase_reg == RSFO_Q4) && dest_file;
    end

    // Write data follows every Q4 and only matters while the strobe is up
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            wdata_reg <= RSFO_DATA_RST;
        else if (phase_reg == RSFO_Q4)
            wdata_reg <= result_reg;
    end

    // Working register changes in Q4 only when the word selects it
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            work_reg <= RSFO_WORK_RST;
        else if ((phase_reg == RSFO_Q4) && dest_work)
            work_reg <= result_reg;
    end

    // Helper for the checks: a read has happened since the last take
    always_ff @(posedge sys_clk)
    begin
        if (rst || instr_take)
            read_done_reg <= 1'h0;
        else if (file_rd)
            read_done_reg <= 1'h1;
    end

    // Assertions
    rot_value_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q3 && is_rot) |=> result_reg == {$past(operand_reg[0]), $past(operand_reg[7:1])})
        else $error("rotate result wrong");
    rot_working_register_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q4 && is_rot && !sel) |=> !file_we && working_register == $past(result_reg))
        else $error("rotate to working register wrong");
    rot_file_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q4 && is_rot && sel) |=> file_we && file_wdata == $past(result_reg)
            && $stable(working_register))
        else $error("rotate to file wrong");
    set_both_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q3 && is_set && !sel) |=> ##1 file_we && file_wdata == 8'hff
            && working_register == 8'hff)
        else $error("set both wrong");
    set_file_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q3 && is_set && sel) |=> ##1 file_we && file_wdata == 8'hff
            && $stable(working_register))
        else $error("set file only wrong");
    phase_seq_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q4) |=> instr_take ##1 !instr_take [*3] ##1 instr_take)
        else $error("phase sequence wrong");
    we_phase_a: assert property (@(posedge sys_clk) disable iff (rst)
        file_we |-> $past(phase_reg) == RSFO_Q4)
        else $error("write outside Q4");
    other_op_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q4 && !is_rot && !is_set) |=> !file_we && $stable(working_register))
        else $error("unknown opcode acted");

    // Operand taken from the file in Q2
    read_data_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q2 && instr_known) |=> operand_reg == $past(file_rdata))
        else $error("read data not taken in Q2");

    // One read per instruction cycle
    read_once_a: assert property (@(posedge sys_clk) disable iff (rst)
        file_rd |=> !file_rd [*3])
        else $error("second read in one cycle");

    // A write never comes before the read of its word
    read_first_a: assert property (@(posedge sys_clk) disable iff (rst)
        file_we |-> read_done_reg)
        else $error("write without a read");

    // The file strobe is a single pulse
    one_write_a: assert property (@(posedge sys_clk) disable iff (rst)
        file_we |=> !file_we)
        else $error("file strobe too long");

    // Working register moves only at the end of Q4
    work_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg != RSFO_Q1) |-> $stable(working_register))
        else $error("working register moved mid cycle");

    // Address stays put so the write lands where the read came from
    addr_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg != RSFO_Q1) |=> $stable(file_addr))
        else $error("file address moved");

    // Set always produces all ones
    set_value_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q4 && is_set) |-> result_reg == RSFO_ALL_ONES)
        else $error("set value wrong");

    // End to end: operand read in Q2 comes back rotated on the write
    rot_wdata_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q4 && is_rot && sel)
            |=> file_wdata == {$past(operand_reg[0]), $past(operand_reg[7:1])})
        else $error("rotated write data wrong");

    // Unknown words do not read the data memory in Q2
    unknown_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        (phase_reg == RSFO_Q2 && !instr_known) |-> !file_rd)
        else $error("unknown word read the file");

    // Reset parks the block in decode with nothing pending
    reset_state_a: assert property (@(posedge sys_clk)
        rst |=> instr_take && !file_we && working_register == RSFO_WORK_RST
            && file_wdata == RSFO_DATA_RST)
        else $error("state after reset wrong");

    // Main scenarios
    rot_cov: cover property (@(posedge sys_clk) phase_reg == RSFO_Q4 && is_rot && sel);
    rotw_cov: cover property (@(posedge sys_clk) phase_reg == RSFO_Q4 && is_rot && !sel);
    set0_cov: cover property (@(posedge sys_clk) phase_reg == RSFO_Q4 && is_set && !sel);
    set1_cov: cover property (@(posedge sys_clk) phase_reg == RSFO_Q4 && is_set && sel);
    unk_cov: cover property (@(posedge sys_clk) phase_reg == RSFO_Q4 && !instr_known);
endmodule : rsfo_exec

// ### test/rsfo_file_mem.sv
// Data memory model facing the execution block
`timescale 1ns/1ps
module rsfo_file_mem
(
    input  wire logic       sys_clk,
    input  wire logic [7:0] file_addr,
    input  wire logic       file_rd,
    output logic      [7:0] file_rdata,
    input  wire logic       file_we,
    input  wire logic [7:0] file_wdata
);
    logic [7:0] mem [256];
    // Inverse when not read, so stale data never passes
    assign file_rdata = file_rd ? mem[file_addr] : ~mem[file_addr];
    always @(posedge sys_clk) if (file_we) mem[file_addr] <= file_wdata;
endmodule : rsfo_file_mem

// ### test/rsfo_exec_test.sv
// Self-checking bench for the rotate and set execution block
`timescale 1ns/1ps
module rsfo_exec_test
    import rsfo_pkg::*;
;
    logic        sys_clk = 0, rst = 1, instr_take, file_rd, file_we, instr_known;
    logic [15:0] instr_word;
    logic [7:0]  file_addr, file_rdata, file_wdata, working_register, v, r, work_exp;
    logic [7:0]  mem_exp [256];
    logic [15:0] plan [6] = '{16'h2000, 16'h21ff, 16'h21ff, 16'h2a3c, 16'h2b3c, 16'h2855};
    logic [25:0] q [$];
    logic [25:0] n;
    int          num_errors = 0, check_count = 0, k, i;
    rsfo_exec u_rsfo_exec (.sys_clk(sys_clk), .rst(rst), .instr_word(instr_word),
        .instr_take(instr_take), .file_addr(file_addr), .file_rd(file_rd), .file_rdata(file_rdata),
        .file_we(file_we), .file_wdata(file_wdata), .working_register(working_register),
        .instr_known(instr_known));
    rsfo_file_mem u_rsfo_file_mem (.sys_clk(sys_clk), .file_addr(file_addr), .file_rd(file_rd),
        .file_rdata(file_rdata), .file_we(file_we), .file_wdata(file_wdata));
    always #5 sys_clk = ~sys_clk;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    // Expected outcome of a taken word; unknown opcodes change nothing
    task automatic note(input logic [15:0] w);
        logic we;
        logic kn;
        we = 1'h0;
        kn = 1'h0;
        v = mem_exp[w[7:0]];
        r = {v[0], v[7:1]};
        if (w[15:9] == RSFO_OP_ROTATE)
        begin
            kn = 1'h1;
            we = w[RSFO_SEL_BIT];
            if (!we) work_exp = r;
        end
        else if (w[15:9] == RSFO_OP_SETONES)
        begin
            kn = 1'h1;
            we = 1'h1;
            r = RSFO_ALL_ONES;
            if (!w[RSFO_SEL_BIT]) work_exp = r;
        end
        if (we) mem_exp[w[7:0]] = r;
        q.push_back({kn, we, w[7:0], r, work_exp});
    endtask : note
    // Mid Q1 the previous instruction's results have settled
    always @(negedge sys_clk)
        if (instr_take === 1'h1 && q.size() > 0)
        begin
            n = q.pop_front();
            check("file_we", {7'h00, file_we}, {7'h00, n[24]});
            if (n[24]) check("file_addr", file_addr, n[23:16]);
            if (n[24]) check("file_wdata", file_wdata, n[15:8]);
            check("working_register", working_register, n[7:0]);
            check("instr_known", {7'h00, instr_known}, {7'h00, n[25]});
        end
    initial
    begin
        void'($urandom(6882));
        for (k = 0; k < 256; k++)
        begin
            mem_exp[k] = 8'($urandom);
            u_rsfo_file_mem.mem[k] = mem_exp[k];
        end
        work_exp = RSFO_WORK_RST;
        instr_word = plan[0];
        repeat (12) @(posedge sys_clk);
        rst <= 1'h0;
        // Back to back words, one per take edge, then random ones
        for (i = 1; i <= 60; i++)
        begin
            @(negedge sys_clk);
            for (k = 0; k < 8 && instr_take !== 1'h1; k++)
                @(negedge sys_clk);
            if (k == 8)
            begin
                num_errors++;
                close_out();
            end
            @(posedge sys_clk);
            note(instr_word);
            v = 8'($urandom);
            instr_word <= i < 6 ? plan[i] : {v[0] ? RSFO_OP_ROTATE : RSFO_OP_SETONES, 9'($urandom)};
        end
        repeat (8) @(posedge sys_clk);
        check("notes left", 8'(q.size()), 8'h00);
        close_out();
    end
endmodule : rsfo_exec_test
